//--- dv/rsm_ref_source.sv
// Behavioural model of the timing sources that feed the reference and sync monitor.
// Assumes a 1 ns time unit and a bench that raises run_i once nominal periods are set.
`timescale 1ns/10ps
module rsm_ref_source (
	input wire logic run_i, // Start all sources
	output logic [7:0] ref_o, // Reference clocks
	output logic [2:0] sync_o // Frame pulse syncs
);
	// ==========================================================
	// Reference clocks
	logic fast;
	logic slow;
	logic sa;
	logic sb;
	// The good references run at 200 ns; the off-frequency one at 125 ns, outside the coarse tolerance but inside the single-cycle one.
	// A phase offset keeps edges away from the bench clock edges.
	initial begin
		fast = 1'b0;
		#1.3;
		forever #100 fast = run_i ? ~fast : 1'b0;
	end
	initial begin
		slow = 1'b0;
		#2.7;
		forever #62.5 slow = run_i ? ~slow : 1'b0;
	end
	// A stopped reference sits low, as a dead clock source would.
	assign ref_o = {{5{fast}}, slow, 1'b0, fast};
	// ==========================================================
	// Frame pulses
	// Wide pulses of 1000 ns period; the second sync lags by 300 ns.
	initial begin
		sa = 1'b0;
		sb = 1'b0;
		wait (run_i === 1'b1);
		#3.1;
		forever begin
			sa = 1'b1;
			#300;
			sb = 1'b1;
			#200;
			sa = 1'b0;
			#300;
			sb = 1'b0;
			#200;
		end
	end
	assign sync_o = {sa, sb, sa};
endmodule

//--- dv/rsm_ref_sync_monitor_tb_top.sv
// Self-checking bench for the reference and sync monitor.
// Assumes the source model above and shortened counts set through parameters.
`timescale 1ns/10ps
module rsm_ref_sync_monitor_tb_top import rsm_pkg::*; ;
	localparam int unsigned FP_TB [6] = '{2400, 1000, 400, 200, 100, 50};
	localparam int unsigned SY_TB [6] = '{2400, 1000, 400, 200, 50, 6};
	localparam logic [19:0] NOM_TB = 20'h00028;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic run = 1'b0;
	logic [7:0] ref_w;
	logic [2:0] sync_w;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [7:0] qualified;
	logic fb;
	logic sonet_a;
	logic sonet_b;
	logic [1:0] prog_fp;
	logic [1:0] prog_a;
	logic [1:0] prog_b;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	int t0 = 0;
	always #2.5 clock_i = ~clock_i;
	always @(posedge clock_i) cyc <= cyc + 1;
	rsm_ref_source i_rsm_ref_source (.run_i(run), .ref_o(ref_w), .sync_o(sync_w));
	rsm_ref_sync_monitor #(.PFM_CYCLES(20000), .CFM_CYCLES(600), .SY_ABSENT(5000), .FP_PER(FP_TB),
		.SY_PER(SY_TB)) i_rsm_ref_sync_monitor (.clock_i(clock_i), .reset_i(reset_i), .ref_i(ref_w),
		.sync_i(sync_w), .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
		.qualified_o(qualified), .loop_feedback_clock_out_o(fb), .sonet_frame_pulse_out_a_o(sonet_a),
		.sonet_frame_pulse_out_b_o(sonet_b), .prog_frame_pulse_out_a_o(prog_fp[0]),
		.prog_frame_pulse_out_b_o(prog_fp[1]),
		.prog_clock_a_o(prog_a), .prog_clock_b_o(prog_b));
	// ==========================================================
	// Common tasks
	task end_of_test;
		$display("Checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task timed_out;
		mismatches++;
		$display("unexpected wait limit at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		end_of_test();
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// The request stands until the edge that samples waitrequest low.
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clock_i);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		for (n = 0; n < 100; n++) begin
			@(posedge clock_i);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n == 100) timed_out();
	endtask
	task set_ctrl(input logic [2:0] sel, input logic [2:0] rate);
		rsm_ctrl_t c;
		logic [31:0] q;
		c = CTRL_RST;
		c.ref_sel = sel;
		c.fp_rate = rate;
		bus(1'b1, REG_CTRL, {20'h0, c}, q);
	endtask
	function automatic logic fp_sig(input int s);
		return (s == 0) ? sonet_a : (s == 1) ? prog_fp[0] : (s == 2) ? prog_fp[1] : sonet_b;
	endfunction
	task pulse_gap(input int s, output int n);
		int i;
		for (i = 0; i < 5000; i++) begin
			@(posedge clock_i);
			if (fp_sig(s) === 1'b1) break;
		end
		for (n = 1; n < 5000; n++) begin
			@(posedge clock_i);
			if (fp_sig(s) === 1'b1) break;
		end
		if (i == 5000 || n == 5000) timed_out();
	endtask
	// Bit 0 picks the first or second clock, bit 1 the synthesizer.
	function automatic logic pclk(input logic [1:0] sel);
		return sel[0] ? prog_b[sel[1]] : prog_a[sel[1]];
	endfunction
	// The half period right after a change is skipped, as it may be cut short.
	task half_check(input logic [1:0] sel, input int exp);
		logic s0;
		int i;
		int n;
		for (i = 0; i < 2; i++) begin
			s0 = pclk(sel);
			for (n = 0; n < 200 && pclk(sel) === s0; n++) @(posedge clock_i);
			s0 = pclk(sel);
			for (n = 0; n < 200 && pclk(sel) === s0; n++) @(posedge clock_i);
		end
		check(32'(n), 32'(exp));
	endtask
	task wait_rise(input int b);
		int i;
		for (i = 0; i < 2000 && sync_w[b] !== 1'b0; i++) @(posedge clock_i);
		if (i == 2000) timed_out();
		for (i = 0; i < 2000 && sync_w[b] !== 1'b1; i++) @(posedge clock_i);
		if (i == 2000) timed_out();
	endtask
	task pulses_in(input int len, output int k);
		int i;
		k = 0;
		for (i = 0; i < len; i++) begin
			@(posedge clock_i);
			if (sonet_a === 1'b1) k++;
		end
	endtask
	// ==========================================================
	// Scenarios
	task sc_reset_values;
		logic [31:0] q;
		check({24'h0, qualified}, 32'h0);
		bus(1'b0, REG_CTRL, 32'h0, q);
		check(q, 32'h0);
		bus(1'b0, REG_PROG0, 32'h0, q);
		check(q, {4'h0, PROG_RST});
		bus(1'b0, REG_NOM0, 32'h0, q);
		check(q, {12'h0, NOM_RST});
		bus(1'b1, 8'h40, 32'hffffffff, q);
		bus(1'b0, 8'h40, 32'h0, q);
		check(q, 32'h0);
		bus(1'b1, REG_STATUS, 32'h000000ff, q);
		bus(1'b0, REG_STATUS, 32'h0, q);
		check({24'h0, q[7:0]}, 32'h0);
	endtask
	task sc_setup;
		logic [31:0] q;
		for (int n = 0; n < 8; n++) bus(1'b1, REG_NOM0 + 8'(4 * n), {12'h0, NOM_TB}, q);
		run <= 1'b1;
		t0 = cyc;
	endtask
	task sc_prog_div;
		logic [31:0] q;
		bus(1'b1, REG_PROG0, {4'h0, 8'h02, 20'h00004}, q);
		bus(1'b1, REG_PROG1, {4'h0, 8'hfe, 20'h00008}, q);
		half_check(2'b00, 4);
		half_check(2'b01, 16);
		half_check(2'b10, 8);
		half_check(2'b11, 2);
		bus(1'b1, REG_PROG0, {4'h0, 8'hff, 20'h00004}, q);
		half_check(2'b01, 2);
	endtask
	// No reference is qualified yet, so the pulses free run at the set rate.
	task sc_fp_rates;
		int n;
		for (int r = 0; r < 6; r++) begin
			set_ctrl(3'd0, 3'(r));
			pulse_gap(0, n);
			pulse_gap(0, n);
			check(32'(n), 32'(FP_TB[r]));
		end
	endtask
	task sc_qualify;
		logic [31:0] q;
		int i;
		for (i = 0; i < 70000 && qualified !== 8'hf9; i++) @(posedge clock_i);
		check({24'h0, qualified}, 32'h000000f9);
		check(32'(cyc - t0 >= 20000), 32'h1);
		bus(1'b0, REG_FAIL, 32'h0, q);
		check({28'h0, q[10], q[8], q[1], q[0]}, 32'ha);
	endtask
	task sc_feedback;
		logic p;
		int k;
		for (int s = 0; s < 2; s++) begin
			set_ctrl(s ? 3'd2 : 3'd0, 3'd3);
			repeat (10) @(posedge clock_i);
			k = 0;
			p = fb;
			for (int i = 0; i < 400; i++) begin
				@(posedge clock_i);
				if (fb === 1'b1 && p === 1'b0) k++;
				p = fb;
			end
			check(32'(k), s ? 32'h0 : 32'ha);
		end
	endtask
	task sc_sync;
		logic [31:0] q;
		int k;
		set_ctrl(3'd0, 3'd3);
		repeat (700) @(posedge clock_i);
		for (int j = 0; j < 3; j++) begin
			wait_rise(0);
			pulses_in(8, k);
			check(32'(k), 32'h1);
			wait_rise(1);
			pulses_in(8, k);
			check(32'(k), 32'h0);
		end
		bus(1'b0, REG_STATUS, 32'h0, q);
		check({26'h0, q[13:8]}, 32'h3e);
		bus(1'b0, REG_SYRATE, 32'h0, q);
		check({23'h0, q[8:0]}, 32'h124);
	endtask
	// Sync 0 arrives every 1000 ns (200 cycles); the free counter wraps every 400 cycles at this rate.
	// Synth 0 stays on the aligned counter, synth 1 moves to the free one.
	task sc_prog_loop;
		rsm_ctrl_t c;
		logic [31:0] q;
		int n;
		c = CTRL_RST;
		c.fp_rate = 3'd2;
		c.prog_sec = 2'b10;
		bus(1'b1, REG_CTRL, {20'h0, c}, q);
		for (int s = 1; s < 4; s++) begin
			pulse_gap(s, n);
			pulse_gap(s, n);
			check(32'(n), (s == 2) ? 32'(FP_TB[2]) : 32'h000000c8);
		end
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge clock_i);
		reset_i <= 1'b0;
		@(posedge clock_i);
		sc_reset_values();
		sc_setup();
		sc_prog_div();
		sc_fp_rates();
		sc_qualify();
		sc_feedback();
		sc_sync();
		sc_prog_loop();
		end_of_test();
	end
endmodule

//--- hdl/rsm_pkg.sv
// Constants, types and register map of the reference and sync monitor.
// Assumes one 200 MHz clock that is also the master oscillator time base.
// Operation
// - Sync n is paired with reference n.
// - Sync inputs never steer the loop.
// - Without sync, frame pulses free run.
// - Only sync rising edges matter.
// - Detect six supported sync rates automatically.
// - Monitor all references; select only qualified.
// - Period off by half flags single-cycle failure.
// - 30 us window, 3 percent flags coarse failure.
// - Precise monitor measures over ten seconds.
// - Precise interval restarts on other failures.
// - Precise monitor uses accept/reject hysteresis.
// - Precise monitor times against master oscillator.
// - Guard soak accumulates failures, decays selectably.
// - Guard soak fails at upper threshold.
// - Guard soak requalifies at lower threshold.
// - Sync fails without correct reference cycle count.
// - Feedback clock follows the selected reference.
// - Programmable synthesizers assignable to either loop.
// - Second clock is first times two power M.
// - Six frame pulse rates; programmable first clocks.
package rsm_pkg;
	// ==========================================================
	// Timing
	localparam int unsigned CLK_NS = 5;
	localparam longint unsigned CLK_HZ = 200_000_000;
	localparam int unsigned CFM_WIN_NS = 30_000;
	localparam int unsigned CFM_CYC = CFM_WIN_NS / CLK_NS;
	localparam int unsigned CFM_TOL = CFM_CYC * 3 / 100;
	localparam longint unsigned PFM_TIME_S = 10;
	localparam longint unsigned PFM_CYC = PFM_TIME_S * CLK_HZ;
	localparam int unsigned FP_NS [6] = '{6_000_000, 2_500_000, 1_000_000, 500_000, 250_000, 125_000};
	localparam int unsigned SY_NS [6] = '{6_000_000, 2_500_000, 1_000_000, 500_000, 125_000, 15_625};
	localparam int unsigned SY_ABSENT_CYC = 2 * SY_NS[0] / CLK_NS;
	localparam logic [7:0] GST_STEP = 8'h08;
	localparam logic [7:0] GST_UPPER = 8'h40;
	localparam logic [7:0] GST_LOWER = 8'h08;
	// ==========================================================
	// Register map (byte offsets)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FAIL = 8'h08;
	localparam logic [7:0] REG_SYRATE = 8'h0c;
	localparam logic [7:0] REG_PROG0 = 8'h10;
	localparam logic [7:0] REG_PROG1 = 8'h14;
	localparam logic [7:0] REG_NOM0 = 8'h20;
	localparam logic [19:0] NOM_RST = 20'h061a8;
	localparam logic [27:0] PROG_RST = 28'h0002ee0;
	// ==========================================================
	// Types
	typedef struct packed {
		logic [3:0] decay;
		logic [2:0] fp_rate;
		logic [1:0] prog_sec;
		logic [2:0] ref_sel;
	} rsm_ctrl_t;
	localparam rsm_ctrl_t CTRL_RST = 12'h000;
	typedef struct packed {
		logic [7:0] gst;
		logic [7:0] precise_frequency_monitor;
		logic [7:0] cfm;
		logic [7:0] scm;
	} rsm_fail_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK = 2'b01
	} rsm_bus_t;
endpackage

//--- hdl/rsm_ref_sync_monitor.sv
// Reference and sync monitor with output frame pulse alignment.
// Assumes asynchronous reference and sync pins and an Avalon-MM master.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module rsm_ref_sync_monitor import rsm_pkg::*; #(
	parameter longint unsigned PFM_CYCLES = PFM_CYC,
	parameter int unsigned CFM_CYCLES = CFM_CYC,
	parameter int unsigned SY_ABSENT = SY_ABSENT_CYC,
	parameter int unsigned FP_PER [6] = '{FP_NS[0] / CLK_NS, FP_NS[1] / CLK_NS, FP_NS[2] / CLK_NS,
		FP_NS[3] / CLK_NS, FP_NS[4] / CLK_NS, FP_NS[5] / CLK_NS},
	parameter int unsigned SY_PER [6] = '{SY_NS[0] / CLK_NS, SY_NS[1] / CLK_NS, SY_NS[2] / CLK_NS,
		SY_NS[3] / CLK_NS, SY_NS[4] / CLK_NS, SY_NS[5] / CLK_NS}
) (
	input wire logic clock_i, // 200 MHz master oscillator clock
	input wire logic reset_i, // Synchronous reset, active high
	input wire logic [7:0] ref_i, // Reference clock pins
	input wire logic [2:0] sync_i, // Frame pulse sync pins
	input wire logic [7:0] avs_address_i, // Byte address
	input wire logic avs_read_i, // Read request
	input wire logic avs_write_i, // Write request
	input wire logic [31:0] avs_writedata_i, // Write data
	output logic [31:0] avs_readdata_o, // Read data
	output logic avs_waitrequest_o, // Stall
	output logic [7:0] qualified_o, // Per-reference qualified
	output logic loop_feedback_clock_out_o, // Primary loop feedback clock
	output logic sonet_frame_pulse_out_a_o, // Frame pulse, primary loop
	output logic sonet_frame_pulse_out_b_o, // Frame pulse, primary loop
	output logic prog_frame_pulse_out_a_o, // Programmable frame pulse
	output logic prog_frame_pulse_out_b_o, // Programmable frame pulse
	output logic [1:0] prog_clock_a_o, // Programmable synth first clocks
	output logic [1:0] prog_clock_b_o // Programmable synth second clocks
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	// ==========================================================
	// Pin synchronisers and rising edges
	logic [10:0] pin_s1_q, pin_s2_q, pin_s3_q;
	logic [7:0] ref_edge;
	logic [2:0] sy_edge;
	always_ff @(posedge clock_i) begin
		pin_s1_q <= {sync_i, ref_i};
		pin_s2_q <= pin_s1_q;
		pin_s3_q <= pin_s2_q;
	end
	assign ref_edge = pin_s2_q[7:0] & ~pin_s3_q[7:0];
	assign sy_edge = pin_s2_q[10:8] & ~pin_s3_q[10:8];

	// ==========================================================
	// Registers and Avalon slave
	rsm_ctrl_t ctrl_q;
	rsm_bus_t bus_q;
	rsm_fail_t fail;
	logic [27:0] prog_q [2];
	logic [19:0] nom_q [8];
	logic [8:0] sy_rate_q;
	logic [2:0] sy_fail_q, sy_present_q;
	logic sel_ok, req, take;
	logic [31:0] rd_d;
	assign req = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = req & (bus_q != BUS_ACK);
	assign take = req & (bus_q == BUS_ACK);
	always_ff @(posedge clock_i) begin
		if (reset_i || take) begin
			bus_q <= BUS_IDLE;
		end else if (req) begin
			bus_q <= BUS_ACK;
		end
	end
	always_comb begin
		rd_d = 32'h0;
		case (avs_address_i)
			REG_CTRL: rd_d = {20'h0, ctrl_q};
			REG_STATUS: rd_d = {17'h0, sel_ok, sy_present_q, sy_fail_q, qualified_o};
			REG_FAIL: rd_d = fail;
			REG_SYRATE: rd_d = {23'h0, sy_rate_q};
			REG_PROG0: rd_d = {4'h0, prog_q[0]};
			REG_PROG1: rd_d = {4'h0, prog_q[1]};
			default: begin
				if (avs_address_i[7:5] == REG_NOM0[7:5] && avs_address_i[1:0] == 2'b00) begin
					rd_d = {12'h0, nom_q[avs_address_i[4:2]]};
				end
			end
		endcase
	end
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			avs_readdata_o <= 32'h0;
		end else if (avs_read_i) begin
			avs_readdata_o <= rd_d;
		end
	end
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ctrl_q <= CTRL_RST;
			prog_q <= '{PROG_RST, PROG_RST};
			nom_q <= '{default: NOM_RST};
		end else if (take && avs_write_i) begin
			if (avs_address_i == REG_CTRL) begin
				ctrl_q <= avs_writedata_i[11:0];
			end
			if (avs_address_i == REG_PROG0 || avs_address_i == REG_PROG1) begin
				prog_q[avs_address_i[2]] <= avs_writedata_i[27:0];
			end
			if (avs_address_i[7:5] == REG_NOM0[7:5] && avs_address_i[1:0] == 2'b00) begin
				nom_q[avs_address_i[4:2]] <= avs_writedata_i[19:0];
			end
		end
	end
	sequence s_req;
		req && avs_waitrequest_o;
	endsequence
	sequence s_ans;
		!avs_waitrequest_o;
	endsequence
	property p_bus_answer;
		s_req |=> s_ans;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not after one stall");

	// ==========================================================
	// Shared coarse window and guard soak decay prescaler
	logic [15:0] cfm_win_q;
	logic [23:0] pre_q;
	logic cfm_end, decay_tick;
	localparam int unsigned CFM_MARGIN = CFM_TOL * CFM_CYCLES / CFM_CYC;
	assign cfm_end = (cfm_win_q == 16'(CFM_CYCLES - 1));
	assign decay_tick = (pre_q & ((24'h1 << (5'(ctrl_q.decay) + 5'h08)) - 24'h1)) == 24'h0;
	always_ff @(posedge clock_i) begin
		if (reset_i || cfm_end) begin
			cfm_win_q <= 16'h0;
		end else begin
			cfm_win_q <= cfm_win_q + 16'h1;
		end
	end
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pre_q <= 24'h0;
		end else begin
			pre_q <= pre_q + 24'h1;
		end
	end

	// ==========================================================
	// Per-reference monitors, all eight run at all times
	for (genvar n = 0; n < 8; n++) begin : g_ref
		logic [20:0] per_q, lim;
		logic [15:0] cfm_cnt_q;
		logic [31:0] pfm_tim_q, pfm_cnt_q;
		logic [35:0] cfm_prod;
		logic [51:0] pfm_prod, pfm_diff;
		logic [7:0] acc_q;
		logic scm_ev, cfm_ev, pfm_end;
		assign lim = {1'b0, nom_q[n]} + 21'(nom_q[n] >> 1);
		assign scm_ev = (ref_edge[n] && (per_q < 21'(nom_q[n] >> 1) || per_q > lim))
			|| (!ref_edge[n] && per_q == lim + 21'h1);
		always_ff @(posedge clock_i) begin
			if (reset_i || ref_edge[n]) begin
				per_q <= 21'h1;
			end else if (per_q != 21'h1fffff) begin
				per_q <= per_q + 21'h1;
			end
		end
		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				fail.scm[n] <= 1'b0;
			end else if (scm_ev) begin
				fail.scm[n] <= 1'b1;
			end else if (ref_edge[n]) begin
				fail.scm[n] <= 1'b0;
			end
		end
		assign cfm_prod = 36'(cfm_cnt_q) * 36'(nom_q[n]);
		assign cfm_ev = cfm_end && (cfm_prod > 36'(CFM_CYCLES + CFM_MARGIN) || cfm_prod + 36'(CFM_MARGIN) < 36'(CFM_CYCLES));
		always_ff @(posedge clock_i) begin
			if (reset_i || cfm_end) begin
				cfm_cnt_q <= 16'(ref_edge[n]);
			end else if (ref_edge[n]) begin
				cfm_cnt_q <= cfm_cnt_q + 16'h1;
			end
		end
		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				fail.cfm[n] <= 1'b0;
			end else if (cfm_end) begin
				fail.cfm[n] <= cfm_ev;
			end
		end
		// Time base is clock_i itself, the master oscillator.
		assign pfm_end = (pfm_tim_q == 32'(PFM_CYCLES - 1));
		assign pfm_prod = 52'(pfm_cnt_q) * 52'(nom_q[n]);
		assign pfm_diff = (pfm_prod > 52'(PFM_CYCLES)) ? pfm_prod - 52'(PFM_CYCLES) : 52'(PFM_CYCLES) - pfm_prod;
		always_ff @(posedge clock_i) begin
			if (reset_i || scm_ev || cfm_ev || pfm_end) begin
				pfm_tim_q <= 32'h0;
				pfm_cnt_q <= 32'(ref_edge[n]);
			end else begin
				pfm_tim_q <= pfm_tim_q + 32'h1;
				pfm_cnt_q <= pfm_cnt_q + 32'(ref_edge[n]);
			end
		end
		// Reject above 1/8192 of the interval, accept below 1/16384.
		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				fail.precise_frequency_monitor[n] <= 1'b1;
			end else if (pfm_end && pfm_diff > 52'(PFM_CYCLES >> 13)) begin
				fail.precise_frequency_monitor[n] <= 1'b1;
			end else if (pfm_end && pfm_diff <= 52'(PFM_CYCLES >> 14)) begin
				fail.precise_frequency_monitor[n] <= 1'b0;
			end
		end
		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				acc_q <= 8'h0;
			end else if (scm_ev || cfm_ev) begin
				acc_q <= (acc_q > 8'hff - GST_STEP) ? 8'hff : acc_q + GST_STEP;
			end else if (decay_tick && acc_q != 8'h0) begin
				acc_q <= acc_q - 8'h1;
			end
		end
		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				fail.gst[n] <= 1'b0;
			end else if (acc_q >= GST_UPPER) begin
				fail.gst[n] <= 1'b1;
			end else if (acc_q <= GST_LOWER) begin
				fail.gst[n] <= 1'b0;
			end
		end
		assign qualified_o[n] = !(fail.scm[n] | fail.cfm[n] | fail.precise_frequency_monitor[n] | fail.gst[n]);
		property p_scm_miss;
			!ref_edge[n] && per_q == lim + 21'h1 |=> fail.scm[n];
		endproperty
		a_scm_miss: assert property (p_scm_miss) else $error("missing edge not flagged");
		property p_pfm_restart;
			scm_ev |=> pfm_tim_q == 32'h0 && pfm_cnt_q == 32'($past(ref_edge[n]));
		endproperty
		a_pfm_restart: assert property (p_pfm_restart) else $error("precise interval not restarted");
		property p_gst_fail;
			acc_q >= GST_UPPER |=> fail.gst[n] ##1 !qualified_o[n];
		endproperty
		a_gst_fail: assert property (p_gst_fail) else $error("guard soak did not disqualify");
		property p_pfm_hyst;
			pfm_end && pfm_diff > 52'(PFM_CYCLES >> 14) && pfm_diff <= 52'(PFM_CYCLES >> 13)
				|=> $stable(fail.precise_frequency_monitor[n]);
		endproperty
		a_pfm_hyst: assert property (p_pfm_hyst) else $error("precise flag moved inside band");
	end

	// ==========================================================
	// Sync monitors and rate detection
	for (genvar n = 0; n < 3; n++) begin : g_sync
		logic [21:0] sp_q;
		logic [15:0] rc_q;
		logic [36:0] rprod;
		logic [2:0] code;
		logic cnt_ok;
		always_comb begin
			code = 3'h0;
			for (int k = 0; k < 6; k++) begin
				if ({10'h0, sp_q} + 32'(SY_PER[k] >> 4) >= SY_PER[k] && {10'h0, sp_q} <= SY_PER[k] + (SY_PER[k] >> 4)) begin
					code = 3'(k + 1);
				end
			end
		end
		// Cycle count check is pinned to reference n.
		assign rprod = 37'(rc_q) * 37'(nom_q[n]);
		assign cnt_ok = rprod + 37'(nom_q[n]) >= 37'(sp_q) && rprod <= 37'(sp_q) + 37'(nom_q[n]);
		always_ff @(posedge clock_i) begin
			if (reset_i || sy_edge[n]) begin
				sp_q <= 22'h1;
				rc_q <= 16'(ref_edge[n]);
			end else begin
				sp_q <= (sp_q == 22'h3fffff) ? sp_q : sp_q + 22'h1;
				rc_q <= rc_q + 16'(ref_edge[n]);
			end
		end
		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				sy_present_q[n] <= 1'b0;
				sy_fail_q[n] <= 1'b0;
				sy_rate_q[3*n +: 3] <= 3'h0;
			end else if (sy_edge[n]) begin
				sy_present_q[n] <= 1'b1;
				if (sy_present_q[n]) begin
					sy_rate_q[3*n +: 3] <= code;
					sy_fail_q[n] <= !cnt_ok || code == 3'h0;
				end
			end else if (sp_q == 22'(SY_ABSENT)) begin
				sy_present_q[n] <= 1'b0;
				sy_fail_q[n] <= 1'b1;
				sy_rate_q[3*n +: 3] <= 3'h0;
			end
		end
		property p_sync_count;
			sy_edge[n] && sy_present_q[n] && !cnt_ok |=> sy_fail_q[n];
		endproperty
		a_sync_count: assert property (p_sync_count) else $error("sync count error not flagged");
	end

	// ==========================================================
	// Selection, feedback clock and frame pulses
	logic [2:0] fp_sel;
	logic [20:0] fpa_q, fpf_q, fp_top;
	logic align, wrap_a, wrap_f, fb_q;
	assign sel_ok = qualified_o[ctrl_q.ref_sel];
	// Sync edges only restart the pulse counter; nothing here feeds the loop.
	assign align = sel_ok && ctrl_q.ref_sel < 3'h3 && sy_edge[ctrl_q.ref_sel[1:0]];
	assign fp_sel = (ctrl_q.fp_rate > 3'h5) ? 3'h5 : ctrl_q.fp_rate;
	assign fp_top = 21'(FP_PER[fp_sel] - 1);
	assign wrap_a = align || fpa_q >= fp_top;
	assign wrap_f = fpf_q >= fp_top;
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			fpa_q <= 21'h0;
			fpf_q <= 21'h0;
		end else begin
			fpa_q <= wrap_a ? 21'h0 : fpa_q + 21'h1;
			fpf_q <= wrap_f ? 21'h0 : fpf_q + 21'h1;
		end
	end
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			sonet_frame_pulse_out_a_o <= 1'b0;
			sonet_frame_pulse_out_b_o <= 1'b0;
			prog_frame_pulse_out_a_o <= 1'b0;
			prog_frame_pulse_out_b_o <= 1'b0;
		end else begin
			sonet_frame_pulse_out_a_o <= wrap_a;
			sonet_frame_pulse_out_b_o <= wrap_a;
			prog_frame_pulse_out_a_o <= ctrl_q.prog_sec[0] ? wrap_f : wrap_a;
			prog_frame_pulse_out_b_o <= ctrl_q.prog_sec[1] ? wrap_f : wrap_a;
		end
	end
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			fb_q <= 1'b0;
		end else begin
			fb_q <= sel_ok & pin_s2_q[ctrl_q.ref_sel];
		end
	end
	assign loop_feedback_clock_out_o = fb_q;
	property p_align;
		align |=> sonet_frame_pulse_out_a_o && fpa_q == 21'h0;
	endproperty
	a_align: assert property (p_align) else $error("frame pulse not aligned to sync");
	property p_fb;
		!sel_ok |=> !loop_feedback_clock_out_o;
	endproperty
	a_fb: assert property (p_fb) else $error("feedback clock from unqualified reference");

	// ==========================================================
	// Programmable synthesizer clocks; the second is 2^M times slower.
	for (genvar p = 0; p < 2; p++) begin : g_prog
		logic [31:0] ca_q, cb_q, half_b;
		logic [19:0] half_a;
		logic signed [7:0] m;
		assign half_a = (prog_q[p][19:0] == 20'h0) ? 20'h1 : prog_q[p][19:0];
		assign m = prog_q[p][27:20];
		// Large shifts saturate rather than wrap; multiply floors at 200 MHz / 2.
		always_comb begin
			if (m > 8'sd12) begin
				half_b = 32'hffffffff;
			end else if (m >= 8'sd0) begin
				half_b = {12'h0, half_a} << m;
			end else if (-m > 8'sd19) begin
				half_b = 32'h1;
			end else begin
				half_b = ({12'h0, half_a} >> (-m) == 32'h0) ? 32'h1 : {12'h0, half_a} >> (-m);
			end
		end
		always_ff @(posedge clock_i) begin
			if (reset_i) begin
				ca_q <= 32'h0;
				cb_q <= 32'h0;
				prog_clock_a_o[p] <= 1'b0;
				prog_clock_b_o[p] <= 1'b0;
			end else begin
				ca_q <= (ca_q + 32'h1 >= {12'h0, half_a}) ? 32'h0 : ca_q + 32'h1;
				prog_clock_a_o[p] <= prog_clock_a_o[p] ^ (ca_q + 32'h1 >= {12'h0, half_a});
				cb_q <= (cb_q + 32'h1 >= half_b) ? 32'h0 : cb_q + 32'h1;
				prog_clock_b_o[p] <= prog_clock_b_o[p] ^ (cb_q + 32'h1 >= half_b);
			end
		end
	end
endmodule
